// ### include/reset_wait_defines.vh
// Constants for the reset, interrupt and wait control block
`ifndef RESET_WAIT_DEFINES_VH
`define RESET_WAIT_DEFINES_VH

// ----------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------
`define WDOG_SERVICE_ADDR 16'hffff

// ----------------------------------------------------------------
// Reset cause bit positions
// ----------------------------------------------------------------
`define CAUSE_POR 7
`define CAUSE_PIN 6
`define CAUSE_WDOG 5
`define CAUSE_ILLEGAL_OPCODE_FLAG 4
`define CAUSE_ILLEGAL_ADDRESS_FLAG 3
`define CAUSE_LVI 1
`define CAUSE_POR_VALUE 8'h80

// ----------------------------------------------------------------
// Prescaler and reset timing, in crystal cycles
// ----------------------------------------------------------------
`define PRESCALE_WIDTH 13
`define PRESCALE_KEEP_BITS 4
`define PIN_LOW_CYCLES 32
`define INTERNAL_RESET_SIGNAL_EXTRA_CYCLES 32
`define LONG_RESET_CYCLES 4096
`define LONG_RELEASE_CYCLES 64
`define STOP_OPCODE 8'h8e

`endif

// ### hdl/prescale_watchdog.v
// Prescale counter and watchdog counter
`timescale 1ns/1ps
`include "reset_wait_defines.vh"
module prescale_watchdog #(
    parameter WDOG_WIDTH = 6
) (
    input wire sys_clk,
    input wire rst,
    input wire xclk_fall,
    input wire clear_all,
    input wire service,
    input wire wdog_enable,
    output reg [`PRESCALE_WIDTH-1:0] prescale_q,
    output reg wdog_overflow_q
);
    reg [WDOG_WIDTH-1:0] wdog_q;
    wire prescale_carry;

    // --------------------------------------------------------------
    // Prescaler
    // --------------------------------------------------------------
    assign prescale_carry = xclk_fall && (&prescale_q);

    // Internal resets clear it; pin reset never reaches here
    always @(posedge sys_clk) begin
        if (rst || clear_all) begin
            prescale_q <= {`PRESCALE_WIDTH{1'b0}};
        end else if (service) begin
            prescale_q <= {{(`PRESCALE_WIDTH-`PRESCALE_KEEP_BITS){1'b0}},
                prescale_q[`PRESCALE_KEEP_BITS-1:0] + {{(`PRESCALE_KEEP_BITS-1){1'b0}}, xclk_fall}};
        end else if (xclk_fall) begin
            prescale_q <= prescale_q + {{(`PRESCALE_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // --------------------------------------------------------------
    // Watchdog counter, stepped by prescaler overflow
    // --------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rst || clear_all || service || !wdog_enable) begin
            wdog_q <= {WDOG_WIDTH{1'b0}};
            wdog_overflow_q <= 1'b0;
        end else if (prescale_carry) begin
            wdog_q <= wdog_q + {{(WDOG_WIDTH-1){1'b0}}, 1'b1};
            wdog_overflow_q <= &wdog_q;
        end else begin
            wdog_overflow_q <= 1'b0;
        end
    end
endmodule // prescale_watchdog

// ### hdl/irq_arbiter.v
// Interrupt latch and priority arbiter
`timescale 1ns/1ps
module irq_arbiter #(
    parameter N_IRQ = 8,
    parameter VEC_WIDTH = 3
) (
    input wire sys_clk,
    input wire rst,
    input wire [N_IRQ-1:0] irq_pending,
    input wire [N_IRQ-1:0] irq_enable,
    input wire allow,
    input wire serviced,
    input wire mask_bit,
    output reg latched_q,
    output reg [VEC_WIDTH-1:0] vector_q
);
    wire [N_IRQ-1:0] live;
    reg [VEC_WIDTH-1:0] pick;
    reg found;
    integer i;
    reg mask_prev_q;

    assign live = irq_pending & irq_enable;

    // Lowest index wins; scan from top so the lowest overwrites
    always @* begin
        pick = {VEC_WIDTH{1'b0}};
        found = 1'b0;
        for (i = N_IRQ - 1; i >= 0; i = i - 1) begin
            if (live[i]) begin
                pick = i[VEC_WIDTH-1:0];
                found = 1'b1;
            end
        end
    end

    // Latched choice holds until serviced or the mask falls; the mask is already clear at latch time
    always @(posedge sys_clk) begin
        mask_prev_q <= rst || mask_bit;
        if (rst) begin
            latched_q <= 1'b0;
            vector_q <= {VEC_WIDTH{1'b0}};
        end else if (latched_q) begin
            if (serviced || (mask_prev_q && !mask_bit)) begin
                latched_q <= 1'b0;
            end
        end else if (allow && found) begin
            latched_q <= 1'b1;
            vector_q <= pick;
        end
    end
endmodule // irq_arbiter

// ### hdl/reset_interrupt_wait_control.v
// Reset sources, interrupt control, break flag protection and wait mode
`timescale 1ns/1ps
`include "reset_wait_defines.vh"
module reset_interrupt_wait_control #(
    parameter N_IRQ = 8,
    parameter VEC_WIDTH = 3,
    parameter WDOG_WIDTH = 6,
    parameter LONG_RESET_CYCLES = `LONG_RESET_CYCLES
) (
    input wire sys_clk,
    input wire rst,
    input wire xclk,
    input wire power_on_reset_signal,
    input wire low_voltage_in,
    input wire reset_pin_in,
    output wire reset_pin_out,
    output wire reset_pin_oe_n,
    input wire reset_pin_high_voltage,
    input wire interrupt_programming_pin_high_voltage,
    input wire monitor_mode,
    input wire break_state,
    input wire watchdog_disable_bit,
    input wire [15:0] cpu_addr,
    input wire cpu_write,
    input wire cpu_read,
    input wire opcode_fetch,
    input wire [7:0] cpu_opcode,
    input wire illegal_opcode_decode,
    input wire addr_is_memory,
    input wire instr_boundary,
    input wire rti_done,
    input wire cpu_mask_bit,
    input wire swi_exec,
    input wire wait_exec,
    input wire irq_serviced,
    input wire [N_IRQ-1:0] irq_pending,
    input wire [N_IRQ-1:0] irq_enable,
    input wire cause_read,
    input wire break_clear_enable,
    input wire break_flag_clear_write,
    input wire flag_clear_request,
    output reg internal_reset_signal,
    output reg [7:0] reset_cause_status_register,
    output reg break_exited_wait_flag,
    output reg wait_mode,
    output wire cpu_clock_enable,
    output reg clear_mask,
    output reg irq_start,
    output reg stack_current_pc,
    output reg [VEC_WIDTH-1:0] irq_vector,
    output wire flag_clear_allowed,
    output wire watchdog_enabled
);
    // ----------------------------------------------------------------
    // Reset sequencer states
    // ----------------------------------------------------------------
    localparam ST_RUN = 2'd0;
    localparam ST_LONG = 2'd1;
    localparam ST_PIN = 2'd2;
    localparam ST_TAIL = 2'd3;
    localparam [12:0] LONG_LAST = LONG_RESET_CYCLES - 1;
    localparam [12:0] PIN_LAST = `PIN_LOW_CYCLES - 1;
    localparam [12:0] TAIL_LAST = `INTERNAL_RESET_SIGNAL_EXTRA_CYCLES - 1;
    localparam [12:0] LONG_TAIL_LAST = `LONG_RELEASE_CYCLES - 1;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    reg [1:0] xclk_s, pin_s, hv_rst_s, hv_irq_s, lvi_s;
    reg xclk_prev_q;
    wire xclk_fall;

    // Pins come from outside, two stages before use
    always @(posedge sys_clk) begin
        if (rst) begin
            xclk_s <= 2'b00;
            pin_s <= 2'b11;
            hv_rst_s <= 2'b00;
            hv_irq_s <= 2'b00;
            lvi_s <= 2'b00;
            xclk_prev_q <= 1'b0;
        end else begin
            xclk_s <= {xclk_s[0], xclk};
            pin_s <= {pin_s[0], reset_pin_in};
            hv_rst_s <= {hv_rst_s[0], reset_pin_high_voltage};
            hv_irq_s <= {hv_irq_s[0], interrupt_programming_pin_high_voltage};
            lvi_s <= {lvi_s[0], low_voltage_in};
            xclk_prev_q <= xclk_s[1];
        end
    end

    assign xclk_fall = xclk_prev_q && !xclk_s[1];

    // ----------------------------------------------------------------
    // Watchdog enable
    // ----------------------------------------------------------------
    // Purely combinational so noise on a pin cannot latch a disable
    assign watchdog_enabled = !watchdog_disable_bit &&
        !(monitor_mode && (hv_rst_s[1] || hv_irq_s[1])) &&
        !(break_state && hv_rst_s[1]);

    // ----------------------------------------------------------------
    // Reset sources
    // ----------------------------------------------------------------
    reg [1:0] state_q;
    reg [12:0] count_q;
    reg long_q;
    reg pin_prev_q;
    wire wdog_overflow;
    wire [`PRESCALE_WIDTH-1:0] prescale;
    wire service;
    wire illegal_opcode_flag_event, illegal_address_flag_event, lvi_event, pin_event, any_internal;

    assign service = cpu_write && (cpu_addr == `WDOG_SERVICE_ADDR);
    assign illegal_opcode_flag_event = instr_boundary && (illegal_opcode_decode ||
        cpu_opcode == `STOP_OPCODE) && opcode_fetch;
    // Data reads are excluded by qualifying with opcode_fetch
    assign illegal_address_flag_event = opcode_fetch && cpu_read && !addr_is_memory;
    assign lvi_event = lvi_s[1];
    assign pin_event = pin_prev_q && !pin_s[1] && reset_pin_oe_n;
    // Sources start the sequence only from ST_RUN; low voltage is ranked above the rest and picks the long reset
    assign any_internal = wdog_overflow || illegal_opcode_flag_event || illegal_address_flag_event || lvi_event;

    prescale_watchdog #(
        .WDOG_WIDTH(WDOG_WIDTH)
    ) u_prescale (
        .sys_clk(sys_clk),
        .rst(rst),
        .xclk_fall(xclk_fall),
        .clear_all(any_internal && state_q == ST_RUN),
        .service(service),
        .wdog_enable(watchdog_enabled),
        .prescale_q(prescale),
        .wdog_overflow_q(wdog_overflow)
    );

    // ----------------------------------------------------------------
    // Reset sequencer, counts crystal falling edges
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ST_LONG;
            count_q <= 13'h0000;
            long_q <= 1'b1;
            pin_prev_q <= 1'b1;
        end else begin
            pin_prev_q <= pin_s[1];
            case (state_q)
                ST_RUN: begin
                    count_q <= 13'h0000;
                    if (lvi_event) begin
                        state_q <= ST_LONG;
                        long_q <= 1'b1;
                    end else if (any_internal) begin
                        state_q <= ST_PIN;
                        long_q <= 1'b0;
                    end
                end
                ST_LONG: begin
                    if (xclk_fall) begin
                        if (count_q == LONG_LAST) begin
                            state_q <= ST_TAIL;
                            count_q <= 13'h0000;
                        end else begin
                            count_q <= count_q + 13'h0001;
                        end
                    end
                end
                ST_PIN: begin
                    if (xclk_fall) begin
                        if (count_q == PIN_LAST) begin
                            state_q <= ST_TAIL;
                            count_q <= 13'h0000;
                        end else begin
                            count_q <= count_q + 13'h0001;
                        end
                    end
                end
                default: begin
                    if (xclk_fall) begin
                        if (count_q == (long_q ? LONG_TAIL_LAST : TAIL_LAST)) begin
                            state_q <= ST_RUN;
                            count_q <= 13'h0000;
                        end else begin
                            count_q <= count_q + 13'h0001;
                        end
                    end
                end
            endcase
        end
    end

    // Open drain: enable low pulls the pin low
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe_n = !(state_q == ST_LONG || state_q == ST_PIN);

    always @(posedge sys_clk) begin
        if (rst) begin
            internal_reset_signal <= 1'b1;
        end else begin
            internal_reset_signal <= (state_q != ST_RUN) || any_internal || !pin_s[1];
        end
    end

    // ----------------------------------------------------------------
    // Reset cause register
    // ----------------------------------------------------------------
    // A cause arriving with the read wins, so the read cannot lose that reason; causes are only recorded in ST_RUN
    always @(posedge sys_clk) begin
        if (rst || power_on_reset_signal) begin
            reset_cause_status_register <= `CAUSE_POR_VALUE;
        end else begin
            if (cause_read) begin
                reset_cause_status_register <= 8'h00;
            end
            if (state_q == ST_RUN && lvi_event) begin
                reset_cause_status_register[`CAUSE_LVI] <= 1'b1;
            end
            if (state_q == ST_RUN && wdog_overflow) begin
                reset_cause_status_register[`CAUSE_WDOG] <= 1'b1;
            end
            if (state_q == ST_RUN && illegal_opcode_flag_event) begin
                reset_cause_status_register[`CAUSE_ILLEGAL_OPCODE_FLAG] <= 1'b1;
            end
            if (state_q == ST_RUN && illegal_address_flag_event) begin
                reset_cause_status_register[`CAUSE_ILLEGAL_ADDRESS_FLAG] <= 1'b1;
            end
            if (state_q == ST_RUN && pin_event) begin
                reset_cause_status_register[`CAUSE_PIN] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    wire latched;
    wire [VEC_WIDTH-1:0] vector;
    wire allow;

    assign allow = !internal_reset_signal && !cpu_mask_bit &&
        (instr_boundary || rti_done || wait_mode);

    irq_arbiter #(
        .N_IRQ(N_IRQ),
        .VEC_WIDTH(VEC_WIDTH)
    ) u_arbiter (
        .sys_clk(sys_clk),
        .rst(rst || internal_reset_signal),
        .irq_pending(irq_pending),
        .irq_enable(irq_enable),
        .allow(allow),
        .serviced(irq_serviced),
        .mask_bit(cpu_mask_bit),
        .latched_q(latched),
        .vector_q(vector)
    );

    reg latched_prev_q;

    // Start pulse on latch; software interrupt bypasses the mask
    always @(posedge sys_clk) begin
        if (rst || internal_reset_signal) begin
            latched_prev_q <= 1'b0;
            irq_start <= 1'b0;
            stack_current_pc <= 1'b0;
            irq_vector <= {VEC_WIDTH{1'b0}};
        end else begin
            latched_prev_q <= latched;
            irq_start <= (latched && !latched_prev_q) || swi_exec;
            stack_current_pc <= swi_exec;
            if (latched && !latched_prev_q) begin
                irq_vector <= vector;
            end
        end
    end

    // ----------------------------------------------------------------
    // Wait mode and break
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rst || internal_reset_signal) begin
            wait_mode <= 1'b0;
            clear_mask <= 1'b0;
        end else begin
            clear_mask <= wait_exec;
            if (wait_exec) begin
                wait_mode <= 1'b1;
            end else if (latched || break_state) begin
                wait_mode <= 1'b0;
            end
        end
    end

    // Only CPU clocks stop; peripherals keep theirs
    assign cpu_clock_enable = !wait_mode;

    // Set wins over the software clear
    always @(posedge sys_clk) begin
        if (rst || internal_reset_signal) begin
            break_exited_wait_flag <= 1'b0;
        end else if (wait_mode && break_state) begin
            break_exited_wait_flag <= 1'b1;
        end else if (break_flag_clear_write) begin
            break_exited_wait_flag <= 1'b0;
        end
    end

    // Either clear step is gated in break, so a step taken before break still needs its partner
    assign flag_clear_allowed = flag_clear_request && (!break_state || break_clear_enable);
endmodule // reset_interrupt_wait_control

// ### verification/reset_pin_partner.sv
// Far-side model of the open-drain reset pin, pull-up and reset switch
`timescale 1ns/1ps
module reset_pin_partner (
    input reset_pin_out,
    input reset_pin_oe_n,
    input ext_pull_low,
    output pin_level
);
    // ----------------------------------------------------------------
    // Wired pin
    // ----------------------------------------------------------------
    // Either party may pull low; the pull-up only wins when both let go
    assign pin_level = ((!reset_pin_oe_n && !reset_pin_out) || ext_pull_low) ? 1'b0 : 1'b1;
endmodule // reset_pin_partner

// ### verification/reset_wait_chk.sv
// Port-level assertions for the reset, interrupt and wait control block
`timescale 1ns/1ps
module reset_wait_chk (
    input sys_clk,
    input rst,
    input reset_pin_out,
    input reset_pin_oe_n,
    input instr_boundary,
    input opcode_fetch,
    input cpu_read,
    input addr_is_memory,
    input illegal_opcode_decode,
    input [7:0] cpu_opcode,
    input internal_reset_signal,
    input [7:0] reset_cause_status_register,
    input wait_exec,
    input wait_mode,
    input clear_mask,
    input cpu_clock_enable,
    input swi_exec,
    input stack_current_pc,
    input break_state,
    input break_exited_wait_flag,
    input break_clear_enable,
    input flag_clear_allowed,
    input reset_pin_high_voltage,
    input watchdog_enabled,
    input cpu_mask_bit,
    input irq_start
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Events are only taken while no reset sequence is running
    wire run = !internal_reset_signal && reset_pin_oe_n;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    illop_reset_a: assert property (
        run && instr_boundary && opcode_fetch && illegal_opcode_decode
        |=> !reset_pin_oe_n && reset_cause_status_register[4] ##1 internal_reset_signal)
        else $error("no illegal opcode reset");
    stop_reset_a: assert property (
        run && instr_boundary && opcode_fetch && cpu_opcode == 8'h8e
        |=> reset_cause_status_register[4] ##1 internal_reset_signal)
        else $error("no stop reset");
    illad_reset_a: assert property (
        run && opcode_fetch && cpu_read && !addr_is_memory |=> !reset_pin_oe_n && reset_cause_status_register[3])
        else $error("no illegal address reset");
    pin_level_a: assert property (!reset_pin_oe_n |-> reset_pin_out == 1'b0 && internal_reset_signal)
        else $error("pin driven without internal reset");
    pin_hold_a: assert property (
        $fell(reset_pin_oe_n) |=> (!reset_pin_oe_n && internal_reset_signal) [*8])
        else $error("pin pulse short");
    cpu_clock_a: assert property (run && wait_exec |=> !cpu_clock_enable)
        else $error("cpu clock runs in wait");
    wait_mask_a: assert property (run && wait_exec && !wait_mode |-> ##[1:2] clear_mask)
        else $error("mask not cleared");
    swi_stack_a: assert property (run && swi_exec |-> ##[1:2] stack_current_pc)
        else $error("current pc not stacked");
    break_wait_a: assert property (run && wait_mode && break_state |-> ##[1:2] break_exited_wait_flag)
        else $error("break wait flag not set");
    flag_guard_a: assert property (break_state && !break_clear_enable |-> !flag_clear_allowed)
        else $error("protected flag cleared");
    wdog_break_a: assert property ((break_state && reset_pin_high_voltage) [*4] |-> !watchdog_enabled)
        else $error("watchdog on in break");
    masked_irq_a: assert property ((cpu_mask_bit && !swi_exec) [*3] |-> !irq_start)
        else $error("masked interrupt started");

    // ----------------------------------------------------------------
    // Coverage
    // ----------------------------------------------------------------
    cover property (run && instr_boundary && opcode_fetch && illegal_opcode_decode);
    cover property (wait_mode && break_state);
    cover property (irq_start);
endmodule // reset_wait_chk

bind reset_interrupt_wait_control reset_wait_chk i_chk (.*);

// ### verification/reset_interrupt_wait_control_test.sv
// Self-checking testbench for the reset, interrupt and wait control block
`timescale 1ns/1ps
module reset_interrupt_wait_control_test;
    // ----------------------------------------------------------------
    // Signals and design
    // ----------------------------------------------------------------
    logic sys_clk = 1'b0, rst = 1'b1, xclk = 1'b0, power_on_reset_signal = 1'b1, low_voltage_in = 1'b0;
    logic reset_pin_high_voltage = 1'b0, interrupt_programming_pin_high_voltage = 1'b0, monitor_mode = 1'b0;
    logic break_state = 1'b0, watchdog_disable_bit = 1'b0, cpu_write = 1'b0, cpu_read = 1'b0;
    logic opcode_fetch = 1'b0, illegal_opcode_decode = 1'b0, addr_is_memory = 1'b1, instr_boundary = 1'b0;
    logic rti_done = 1'b0, cpu_mask_bit = 1'b1, swi_exec = 1'b0, wait_exec = 1'b0, irq_serviced = 1'b0;
    logic cause_read = 1'b0, break_clear_enable = 1'b0, break_flag_clear_write = 1'b0, flag_clear_request = 1'b0;
    logic ext_pull_low = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0] cpu_opcode = 8'h9d, irq_pending = 8'h00, irq_enable = 8'h00, reset_cause_status_register;
    logic [2:0] irq_vector;
    wire reset_pin_out, reset_pin_oe_n, pin_level, cpu_clock_enable, flag_clear_allowed, watchdog_enabled;
    logic internal_reset_signal, break_exited_wait_flag, wait_mode, clear_mask, irq_start, stack_current_pc;
    int num_errors = 0, num_checks = 0;
    logic [11:0] cnt;

    // Short long-reset count keeps the run brief
    reset_interrupt_wait_control #(.LONG_RESET_CYCLES(16)) i_dut (.reset_pin_in(pin_level), .*);
    reset_pin_partner i_pin (.reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n),
        .ext_pull_low(ext_pull_low), .pin_level(pin_level));

    // Crystal at a quarter of the system rate
    always #5 sys_clk = ~sys_clk;
    always #20 xclk = ~xclk;

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Signals that wait_on can poll, by index
    wire [3:0] watch = {stack_current_pc, !reset_pin_oe_n, irq_start, internal_reset_signal};

    // Polls at falling edges so every sample sees settled outputs
    task automatic wait_on(input int s, input logic v);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
            if (n > 3000) begin
                num_errors++;
                stop_test;
            end
        end while (watch[s] !== v);
        num_checks++;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        power_on_reset_signal <= 1'b0;
        @(negedge sys_clk) chk(reset_cause_status_register, 8'h80);
        wait_on(0, 1'b0);
        @(posedge sys_clk);
        cpu_write <= 1'b1;
        cpu_addr <= 16'hffff;
        cause_read <= 1'b1;
        @(posedge sys_clk);
        cpu_write <= 1'b0;
        cause_read <= 1'b0;
        @(negedge sys_clk) chk(reset_cause_status_register, 8'h00);
        // Unmapped data read must not reset
        @(posedge sys_clk);
        cpu_read <= 1'b1;
        addr_is_memory <= 1'b0;
        repeat (3) @(posedge sys_clk);
        cpu_read <= 1'b0;
        addr_is_memory <= 1'b1;
        repeat (40) @(negedge sys_clk);
        chk({reset_pin_oe_n, internal_reset_signal}, 8'h02);
        // Each reset source but the watchdog: cause flag, release, and pin pulse length for all but the pin source
        for (int k = 0; k < 5; k++) begin
            @(posedge sys_clk);
            case (k)
                0: {instr_boundary, opcode_fetch, cpu_read, illegal_opcode_decode} <= 4'hf;
                1: {instr_boundary, opcode_fetch, cpu_read, cpu_opcode} <= {3'h7, 8'h8e};
                2: {opcode_fetch, cpu_read, addr_is_memory} <= 3'h6;
                3: low_voltage_in <= 1'b1;
                default: ext_pull_low <= 1'b1;
            endcase
            repeat (k == 4 ? 300 : (k == 3 ? 4 : 1)) @(posedge sys_clk);
            {instr_boundary, opcode_fetch, cpu_read, illegal_opcode_decode, low_voltage_in, ext_pull_low} <= 6'h00;
            cpu_opcode <= 8'h9d;
            addr_is_memory <= 1'b1;
            if (k < 4) begin
                wait_on(2, 1'b1);
                cnt = 0;
                while (reset_pin_oe_n === 1'b0 && cnt < 3000) begin
                    @(negedge sys_clk);
                    cnt++;
                end
                chk(cnt >= (k == 3 ? 52 : 116) && cnt <= (k == 3 ? 72 : 136), 8'h01);
            end
            wait_on(0, 1'b0);
            chk(reset_cause_status_register, k == 4 ? 8'h40 : 8'h10 >> (k == 3 ? 3 : k / 2));
            @(posedge sys_clk) cause_read <= 1'b1;
            @(posedge sys_clk) cause_read <= 1'b0;
            @(negedge sys_clk) chk(reset_cause_status_register, 8'h00);
        end
        // Wait, then wake on two pending interrupts
        @(posedge sys_clk) wait_exec <= 1'b1;
        @(posedge sys_clk) wait_exec <= 1'b0;
        repeat (2) @(negedge sys_clk);
        chk({wait_mode, cpu_clock_enable, watchdog_enabled}, 8'h05);
        @(posedge sys_clk);
        cpu_mask_bit <= 1'b0;
        irq_pending <= 8'h06;
        irq_enable <= 8'h06;
        wait_on(1, 1'b1);
        chk(irq_vector, 8'h01);
        @(posedge sys_clk);
        {cpu_mask_bit, irq_serviced, irq_pending} <= {2'h3, 8'h04};
        @(posedge sys_clk) irq_serviced <= 1'b0;
        repeat (3) @(negedge sys_clk);
        chk(wait_mode, 8'h00);
        @(posedge sys_clk) {cpu_mask_bit, rti_done} <= 2'h1;
        @(posedge sys_clk) rti_done <= 1'b0;
        wait_on(1, 1'b1);
        chk(irq_vector, 8'h02);
        // Pending but not enabled, then enabled but masked: nothing starts
        @(posedge sys_clk) {cpu_mask_bit, irq_serviced, irq_pending, irq_enable} <= {2'h3, 8'h01, 8'h00};
        @(posedge sys_clk) {cpu_mask_bit, irq_serviced, instr_boundary} <= 3'h1;
        for (int m = 0; m < 2; m++) begin
            cnt = 0;
            repeat (10) begin
                @(negedge sys_clk);
                cnt += irq_start;
            end
            chk(cnt, 8'h00);
            @(posedge sys_clk) {cpu_mask_bit, irq_enable} <= {1'b1, 8'h01};
        end
        @(posedge sys_clk) cpu_mask_bit <= 1'b0;
        wait_on(1, 1'b1);
        chk(irq_vector, 8'h00);
        @(posedge sys_clk) {cpu_mask_bit, irq_serviced, irq_pending, instr_boundary} <= {2'h3, 8'h00, 1'b0};
        @(posedge sys_clk) {irq_serviced, swi_exec} <= 2'h1;
        @(posedge sys_clk) swi_exec <= 1'b0;
        wait_on(3, 1'b1);
        // Break during wait, then clear its flag
        @(posedge sys_clk) wait_exec <= 1'b1;
        @(posedge sys_clk) wait_exec <= 1'b0;
        @(posedge sys_clk) break_state <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk({break_exited_wait_flag, wait_mode}, 8'h02);
        // Flag protection while in break
        @(posedge sys_clk) flag_clear_request <= 1'b1;
        @(negedge sys_clk) chk(flag_clear_allowed, 8'h00);
        @(posedge sys_clk) break_clear_enable <= 1'b1;
        @(negedge sys_clk) chk(flag_clear_allowed, 8'h01);
        @(posedge sys_clk) {break_state, break_clear_enable, break_flag_clear_write} <= 3'h1;
        @(negedge sys_clk) chk(flag_clear_allowed, 8'h01);
        @(posedge sys_clk) {break_flag_clear_write, flag_clear_request} <= 2'h0;
        @(negedge sys_clk) chk(break_exited_wait_flag, 8'h00);
        // Only qualified high voltage or the configuration bit may stop the watchdog
        for (int w = 0; w < 6; w++) begin
            @(posedge sys_clk);
            {watchdog_disable_bit, monitor_mode, interrupt_programming_pin_high_voltage, break_state,
                reset_pin_high_voltage} <= 5'(30'h2090_0c8c >> (5 * w));
            repeat (5) @(negedge sys_clk);
            chk(watchdog_enabled, (8'h0a >> w) & 8'h01);
        end
        stop_test;
    end
endmodule // reset_interrupt_wait_control_test
